/* design/sspi_top.sv */
`timescale 1ns/1ps
`default_nettype none
`include "sspi_cfg.svh"
module sspi_top #(
  parameter int ADDR_W = 10
) (
  // clock and reset
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  // wishbone classic slave
  input  wire logic              wb_cyc_i,
  input  wire logic              wb_stb_i,
  input  wire logic              wb_we_i,
  input  wire logic [ADDR_W-1:0] wb_adr_i,
  input  wire logic [3:0]        wb_sel_i,
  input  wire logic [31:0]       wb_dat_i,
  output logic      [31:0]       wb_dat_o,
  output logic                   wb_ack_o,
  // measured coil current frequency, 2 Hz per count, same clock
  input  wire logic [8:0]        coil_freq_i,
  // regulation controls
  output logic                   silent_active_o,
  output logic                   alt_decay_o,
  output logic      [15:0]       eff_kp_o,
  output logic      [15:0]       eff_ki_o
);

  // ****************************************************************
  // state
  // ****************************************************************
  logic                   en_reg,   en_next;
  sspi_pkg::sspi_gain_t   kp_reg,   kp_next;
  sspi_pkg::sspi_gain_t   ki_reg,   ki_next;
  sspi_pkg::sspi_div_sel_t kp_sel_reg, kp_sel_next;
  sspi_pkg::sspi_div_sel_t ki_sel_reg, ki_sel_next;
  logic [7:0]             thr_reg,  thr_next;
  logic                   ack_reg,  ack_next;
  logic [31:0]            dat_reg,  dat_next;
  sspi_pkg::sspi_mode_t   mode_reg, mode_next;
  logic                   silent_reg, silent_next;
  logic                   alt_reg,  alt_next;
  logic [15:0]            kp_out_reg, kp_out_next;
  logic [15:0]            ki_out_reg, ki_out_next;

  logic [7:0]             idx;
  logic                   req;
  logic                   wr;
  logic                   above;
  logic [15:0]            kp_scaled;
  logic [15:0]            ki_scaled;

  // ****************************************************************
  // gain dividers
  // ****************************************************************
  sspi_gain_shift i_sspi_gain_shift_kp (
    .gain_i    (kp_reg),
    .div_sel_i (kp_sel_reg),
    .eff_o     (kp_scaled)
  );

  sspi_gain_shift i_sspi_gain_shift_ki (
    .gain_i    (ki_reg),
    .div_sel_i (ki_sel_reg),
    .eff_o     (ki_scaled)
  );

  // ****************************************************************
  // bus decode
  // ****************************************************************
  // low two address bits are ignored: every register is one word
  assign idx = wb_adr_i[9:2];
  assign req = wb_cyc_i & wb_stb_i;
  // write lands on the edge where ack is seen, only lane 0 carries data
  assign wr  = req & wb_we_i & ack_reg & wb_sel_i[0];

  // read mux, unmapped words read as zero
  function automatic logic [31:0] rd_word(input logic [7:0] a);
    logic [31:0] d;
    d = 32'h0000_0000;
    case (a)
      `SSPI_IDX_ENABLE:   d[`SSPI_ENABLE_BIT] = en_reg;
      `SSPI_IDX_PROP:     d[6:0] = kp_reg;
      `SSPI_IDX_INTEGRAL: d[6:0] = ki_reg;
      `SSPI_IDX_DIVIDER:  d[7:0] = {1'b0, ki_sel_reg, 1'b0, kp_sel_reg};
      `SSPI_IDX_HANDOVER: d[7:0] = thr_reg;
      `SSPI_IDX_STATUS:   d[1:0] = {alt_reg, silent_reg};
      default:            d = 32'h0000_0000;
    endcase
    return d;
  endfunction

  // ack one cycle after the request, dropped the cycle after
  always_comb begin
    ack_next = req & ~ack_reg;
    dat_next = dat_reg;
    if (req & ~ack_reg) begin
      dat_next = rd_word(idx);
    end
  end

  // ****************************************************************
  // configuration registers
  // ****************************************************************
  // reserved bits are not stored and read back as zero
  always_comb begin
    en_next     = en_reg;
    kp_next     = kp_reg;
    ki_next     = ki_reg;
    kp_sel_next = kp_sel_reg;
    ki_sel_next = ki_sel_reg;
    thr_next    = thr_reg;
    if (wr) begin
      case (idx)
        `SSPI_IDX_ENABLE:   en_next = wb_dat_i[`SSPI_ENABLE_BIT];
        `SSPI_IDX_PROP:     kp_next = wb_dat_i[`SSPI_GAIN_MSB:`SSPI_GAIN_LSB];
        `SSPI_IDX_INTEGRAL: ki_next = wb_dat_i[`SSPI_GAIN_MSB:`SSPI_GAIN_LSB];
        `SSPI_IDX_DIVIDER: begin
          ki_sel_next = wb_dat_i[`SSPI_KI_DIV_MSB:`SSPI_KI_DIV_LSB];
          kp_sel_next = wb_dat_i[`SSPI_KP_DIV_MSB:`SSPI_KP_DIV_LSB];
        end
        // a zero code is stored as written; keeping it out is up to software
        `SSPI_IDX_HANDOVER: thr_next = wb_dat_i[7:0];
        default: begin
        end
      endcase
    end
  end

  // ****************************************************************
  // regulation scheme selection
  // ****************************************************************
  // threshold and measurement share the 2 Hz unit, so compare codes
  assign above = coil_freq_i > {1'b0, thr_reg};

  always_comb begin
    if (!en_reg) begin
      mode_next = sspi_pkg::SSPI_MODE_OFF;
    end else if (above) begin
      mode_next = sspi_pkg::SSPI_MODE_ALT;
    end else begin
      mode_next = sspi_pkg::SSPI_MODE_SILENT;
    end
    silent_next = (mode_next == sspi_pkg::SSPI_MODE_SILENT);
    alt_next    = (mode_next == sspi_pkg::SSPI_MODE_ALT);
    // gains only reach the loop in the silent step scheme, zero under alternative decay
    kp_out_next = silent_next ? kp_scaled : 16'h0000;
    ki_out_next = silent_next ? ki_scaled : 16'h0000;
  end

  // ****************************************************************
  // registers
  // ****************************************************************
  // bus answer: ack pulse and read data
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg <= 1'b0;
      dat_reg <= 32'h0000_0000;
    end else begin
      ack_reg <= ack_next;
      dat_reg <= dat_next;
    end
  end

  // configuration fields; a write lands only on the ack edge
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      en_reg     <= `SSPI_RST_ENABLE;
      kp_reg     <= `SSPI_RST_GAIN;
      ki_reg     <= `SSPI_RST_GAIN;
      kp_sel_reg <= `SSPI_RST_DIV;
      ki_sel_reg <= `SSPI_RST_DIV;
      thr_reg    <= `SSPI_RST_THR;
    end else begin
      en_reg     <= en_next;
      kp_reg     <= kp_next;
      ki_reg     <= ki_next;
      kp_sel_reg <= kp_sel_next;
      ki_sel_reg <= ki_sel_next;
      thr_reg    <= thr_next;
    end
  end

  // regulation outputs trail their cause by a cycle, traded for glitch-free pins
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mode_reg   <= sspi_pkg::SSPI_MODE_OFF;
      silent_reg <= 1'b0;
      alt_reg    <= 1'b0;
      kp_out_reg <= 16'h0000;
      ki_out_reg <= 16'h0000;
    end else begin
      mode_reg   <= mode_next;
      silent_reg <= silent_next;
      alt_reg    <= alt_next;
      kp_out_reg <= kp_out_next;
      ki_out_reg <= ki_out_next;
    end
  end

  // outputs straight from flops
  assign wb_ack_o        = ack_reg;
  assign wb_dat_o        = dat_reg;
  assign silent_active_o = silent_reg;
  assign alt_decay_o     = alt_reg;
  assign eff_kp_o        = kp_out_reg;
  assign eff_ki_o        = ki_out_reg;

  // ****************************************************************
  // assertions
  // ****************************************************************
  sequence s_new_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence

  sequence s_ack_once;
    wb_ack_o ##1 !wb_ack_o;
  endsequence

  a_bus_ack_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
    s_new_req |=> s_ack_once)
    else $error("ack not a single cycle after request");

  a_prop_gain_write: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr && idx == `SSPI_IDX_PROP) |=> kp_reg == $past(wb_dat_i[6:0]))
    else $error("proportional gain not stored");

  a_integral_gain_write: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr && idx == `SSPI_IDX_INTEGRAL) |=>
      ki_reg == $past(wb_dat_i[6:0]) && kp_reg == $past(kp_reg))
    else $error("integral gain not stored or disturbed proportional gain");

  a_ki_undivided: assert property (@(posedge clk_i) disable iff (rst_i)
    (ki_sel_reg == 3'h6 && silent_next) |=> eff_ki_o == {$past(ki_reg), 9'h000})
    else $error("integral code 110 must not divide");

  a_kp_div_sixteen: assert property (@(posedge clk_i) disable iff (rst_i)
    (kp_sel_reg == 3'h5 && silent_next) |=> eff_kp_o == {4'h0, $past(kp_reg), 5'h00})
    else $error("proportional code 101 must divide by 16");

  a_handover_above: assert property (@(posedge clk_i) disable iff (rst_i)
    (en_reg && coil_freq_i > {1'b0, thr_reg}) |=>
      alt_decay_o && !silent_active_o && eff_kp_o == 16'h0000)
    else $error("above threshold must use the alternative decay");

  a_thr_reset_ones: assert property (@(posedge clk_i) disable iff (rst_i)
    $fell(rst_i) |-> thr_reg == 8'hff && kp_sel_reg == 3'h0 && !silent_active_o)
    else $error("threshold or divider reset value wrong");

  a_disabled_quiet: assert property (@(posedge clk_i) disable iff (rst_i)
    !en_reg [*2] |-> !silent_active_o && !alt_decay_o && eff_ki_o == 16'h0000)
    else $error("disabled loop still regulating");

  a_undef_code_div: assert property (@(posedge clk_i) disable iff (rst_i)
    (kp_sel_reg == 3'h7 && silent_next) |=> eff_kp_o == {5'h00, $past(kp_reg), 4'h0})
    else $error("code 111 must act as divide by 32");

  a_ki_undef_code: assert property (@(posedge clk_i) disable iff (rst_i)
    (ki_sel_reg == 3'h7 && silent_next) |=> eff_ki_o == {5'h00, $past(ki_reg), 4'h0})
    else $error("integral code 111 must act as divide by 32");

  a_kp_div_default: assert property (@(posedge clk_i) disable iff (rst_i)
    (kp_sel_reg == 3'h0 && silent_next) |=> eff_kp_o == {5'h00, $past(kp_reg), 4'h0})
    else $error("proportional code 000 must divide by 32");

  a_kp_div_max: assert property (@(posedge clk_i) disable iff (rst_i)
    (kp_sel_reg == 3'h4 && silent_next) |=> eff_kp_o == {9'h000, $past(kp_reg)})
    else $error("proportional code 100 must divide by 512");

  a_ki_div_max: assert property (@(posedge clk_i) disable iff (rst_i)
    (ki_sel_reg == 3'h4 && silent_next) |=> eff_ki_o == {9'h000, $past(ki_reg)})
    else $error("integral code 100 must divide by 512");

  a_handover_below: assert property (@(posedge clk_i) disable iff (rst_i)
    (en_reg && coil_freq_i <= {1'b0, thr_reg}) |=> silent_active_o && !alt_decay_o)
    else $error("at or below threshold must stay in silent step");

  // the flag pins and the scheme register must never tell different stories
  a_mode_flags: assert property (@(posedge clk_i) disable iff (rst_i)
    silent_active_o == (mode_reg == sspi_pkg::SSPI_MODE_SILENT) &&
      alt_decay_o == (mode_reg == sspi_pkg::SSPI_MODE_ALT))
    else $error("regulation flags disagree with the scheme in force");

  a_enable_write: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr && idx == `SSPI_IDX_ENABLE) |=> en_reg == $past(wb_dat_i[`SSPI_ENABLE_BIT]))
    else $error("enable bit not stored");

  a_divider_write: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr && idx == `SSPI_IDX_DIVIDER) |=>
      ki_sel_reg == $past(wb_dat_i[`SSPI_KI_DIV_MSB:`SSPI_KI_DIV_LSB]) &&
      kp_sel_reg == $past(wb_dat_i[`SSPI_KP_DIV_MSB:`SSPI_KP_DIV_LSB]))
    else $error("divider codes not stored");

  a_thr_write: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr && idx == `SSPI_IDX_HANDOVER) |=> thr_reg == $past(wb_dat_i[7:0]))
    else $error("handover threshold not stored");

  a_lane_off_write: assert property (@(posedge clk_i) disable iff (rst_i)
    (req && wb_we_i && ack_reg && !wb_sel_i[0]) |=>
      $stable(kp_reg) && $stable(ki_reg) && $stable(thr_reg) && $stable(en_reg))
    else $error("write with lane 0 off changed a register");

  a_ack_needs_req: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without a request");

endmodule
`default_nettype wire

/* pkg/sspi_cfg.svh */
`ifndef SSPI_CFG_SVH
`define SSPI_CFG_SVH

// ****************************************************************
// register indices (byte address is four times the index)
// ****************************************************************
`define SSPI_IDX_ENABLE    8'h31
`define SSPI_IDX_PROP      8'h32
`define SSPI_IDX_INTEGRAL  8'h33
`define SSPI_IDX_DIVIDER   8'h34
`define SSPI_IDX_HANDOVER  8'h35
`define SSPI_IDX_STATUS    8'h36

// ****************************************************************
// field positions
// ****************************************************************
`define SSPI_ENABLE_BIT    0
`define SSPI_GAIN_MSB      6
`define SSPI_GAIN_LSB      0
`define SSPI_KI_DIV_MSB    6
`define SSPI_KI_DIV_LSB    4
`define SSPI_KP_DIV_MSB    2
`define SSPI_KP_DIV_LSB    0
`define SSPI_STAT_SILENT   0
`define SSPI_STAT_ALT      1

// ****************************************************************
// reset values
// ****************************************************************
`define SSPI_RST_ENABLE    1'h0
`define SSPI_RST_GAIN      7'h00
`define SSPI_RST_DIV       3'h0
`define SSPI_RST_THR       8'hff

// ****************************************************************
// scaling
// ****************************************************************
`define SSPI_THR_HZ_PER_CODE 2
`define SSPI_FRAC_BITS       9

`endif

/* pkg/sspi_pkg.sv */
`default_nettype none
package sspi_pkg;

  // programmed gain and divider code
  typedef logic [6:0] sspi_gain_t;
  typedef logic [2:0] sspi_div_sel_t;
  typedef logic [3:0] sspi_shift_t;

  // regulation scheme in force
  typedef enum logic [1:0] {
    SSPI_MODE_OFF,
    SSPI_MODE_SILENT,
    SSPI_MODE_ALT
  } sspi_mode_t;

  // divider code to right-shift amount; 111 falls back to 000
  function automatic sspi_shift_t sspi_div_shift(input sspi_div_sel_t sel);
    sspi_shift_t sh;
    sh = 4'h5;
    case (sel)
      3'h0: sh = 4'h5;
      3'h1: sh = 4'h6;
      3'h2: sh = 4'h7;
      3'h3: sh = 4'h8;
      3'h4: sh = 4'h9;
      3'h5: sh = 4'h4;
      3'h6: sh = 4'h0;
      default: sh = 4'h5;
    endcase
    return sh;
  endfunction

endpackage
`default_nettype wire

/* design/sspi_gain_shift.sv */
`timescale 1ns/1ps
`default_nettype none
`include "sspi_cfg.svh"
module sspi_gain_shift (
  // programmed values
  input  wire logic [6:0]  gain_i,
  input  wire logic [2:0]  div_sel_i,
  // effective gain, fixed point with nine fraction bits
  output logic      [15:0] eff_o
);

  // ****************************************************************
  // divide by shifting
  // ****************************************************************
  // gain is placed above the fraction first so /512 keeps every bit
  logic [15:0] wide;
  assign wide  = {gain_i, 9'h000};
  assign eff_o = wide >> sspi_pkg::sspi_div_shift(div_sel_i);

endmodule
`default_nettype wire

/* testbench/tb_sspi_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_sspi_top;
  // ****************************************************************
  // signals
  // ****************************************************************
  logic        clk_i;
  logic        rst_i;
  logic        wb_cyc_i;
  logic        wb_stb_i;
  logic        wb_we_i;
  logic [9:0]  wb_adr_i;
  logic [3:0]  wb_sel_i;
  logic [31:0] wb_dat_i;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o;
  logic [8:0]  coil_freq_i;
  logic        silent_active_o;
  logic        alt_decay_o;
  logic [15:0] eff_kp_o;
  logic [15:0] eff_ki_o;
  int          n_fail;
  int          compares;
  logic [31:0] q;

  sspi_top #(.ADDR_W(10)) i_sspi_top (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .coil_freq_i(coil_freq_i),
    .silent_active_o(silent_active_o), .alt_decay_o(alt_decay_o),
    .eff_kp_o(eff_kp_o), .eff_ki_o(eff_ki_o)
  );

  // 25 MHz clock
  always #20 clk_i = ~clk_i;

  // ****************************************************************
  // helpers
  // ****************************************************************
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic summarize;
    $display("compares=%0d n_fail=%0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // one classic cycle; ack is awaited, never assumed, and a hang ends the run
  task automatic bus(input logic we, input logic [7:0] idx, input logic [7:0] d,
                     input logic s0, output logic [31:0] rd);
    int i;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= {idx, 2'b00};
    wb_sel_i <= {3'h0, s0};
    wb_dat_i <= {24'h000000, d};
    for (i = 0; i < 20; i++) begin
      @(posedge clk_i);
      if (wb_ack_o === 1'b1) break;
    end
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i  <= 1'b0;
    if (i == 20) begin
      n_fail++;
      summarize();
    end
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [31:0] dummy;
    bus(1'b1, idx, d, 1'b1, dummy);
  endtask

  // outputs are registered behind the registers, so let a few edges pass;
  // reads happen on the edge itself and see the value settled before it
  task automatic settle;
    repeat (3) @(posedge clk_i);
  endtask

  // codes 101 and 110 sit out of order; 111 falls back to the /32 shift
  function automatic logic [15:0] exp_eff(input logic [6:0] g, input logic [2:0] c);
    int sh;
    sh = (c == 3'h5) ? 4 : (c == 3'h6) ? 0 : (c == 3'h7) ? 5 : 5 + int'(c);
    return {g, 9'h000} >> sh;
  endfunction

  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_reset;
    bus(1'b0, 8'h31, 8'h00, 1'b1, q);
    chk(q, 32'h0);
    bus(1'b0, 8'h32, 8'h00, 1'b1, q);
    chk(q, 32'h0);
    bus(1'b0, 8'h33, 8'h00, 1'b1, q);
    chk(q, 32'h0);
    bus(1'b0, 8'h34, 8'h00, 1'b1, q);
    chk(q, 32'h0);
    bus(1'b0, 8'h35, 8'h00, 1'b1, q);
    chk(q, 32'hff);
    chk({30'h0, silent_active_o, alt_decay_o}, 32'h0);
  endtask

  task automatic t_regs;
    wr(8'h32, 8'hff);
    bus(1'b0, 8'h32, 8'h00, 1'b1, q);
    chk(q, 32'h7f);
    wr(8'h33, 8'hff);
    bus(1'b0, 8'h33, 8'h00, 1'b1, q);
    chk(q, 32'h7f);
    wr(8'h34, 8'hff);
    bus(1'b0, 8'h34, 8'h00, 1'b1, q);
    chk(q, 32'h77);
    wr(8'h35, 8'h80);
    bus(1'b0, 8'h35, 8'h00, 1'b1, q);
    chk(q, 32'h80);
    // byte lane off: write must leave the gain alone
    bus(1'b1, 8'h32, 8'h11, 1'b0, q);
    bus(1'b0, 8'h32, 8'h00, 1'b1, q);
    chk(q, 32'h7f);
    wr(8'h40, 8'h5a);
    bus(1'b0, 8'h40, 8'h00, 1'b1, q);
    chk(q, 32'h0);
  endtask

  // every divider code on both gains, the two in opposite order
  task automatic t_div;
    logic [2:0] c;
    wr(8'h35, 8'hff);
    wr(8'h31, 8'h01);
    for (int k = 0; k < 8; k++) begin
      c = k[2:0];
      wr(8'h34, {1'b0, ~c, 1'b0, c});
      settle();
      chk({16'h0, eff_kp_o}, {16'h0, exp_eff(7'h7f, c)});
      chk({16'h0, eff_ki_o}, {16'h0, exp_eff(7'h7f, ~c)});
      chk({31'h0, silent_active_o}, 32'h1);
    end
    bus(1'b0, 8'h36, 8'h00, 1'b1, q);
    chk(q, 32'h1);
  endtask

  // equal frequency stays silent, one count above hands over
  task automatic t_thr;
    logic [7:0] thr [3] = '{8'h01, 8'h80, 8'hff};
    for (int k = 0; k < 3; k++) begin
      wr(8'h35, thr[k]);
      @(posedge clk_i);
      coil_freq_i <= {1'b0, thr[k]};
      settle();
      chk({30'h0, silent_active_o, alt_decay_o}, 32'h2);
      coil_freq_i <= {1'b0, thr[k]} + 9'h001;
      settle();
      chk({30'h0, silent_active_o, alt_decay_o}, 32'h1);
      chk({eff_kp_o, eff_ki_o}, 32'h0);
    end
    bus(1'b0, 8'h36, 8'h00, 1'b1, q);
    chk(q, 32'h2);
  endtask

  // disabled: no regulation output whatever the frequency
  task automatic t_disable;
    wr(8'h31, 8'h00);
    settle();
    chk({30'h0, silent_active_o, alt_decay_o}, 32'h0);
    coil_freq_i <= 9'h000;
    settle();
    chk({31'h0, silent_active_o}, 32'h0);
    chk({eff_kp_o, eff_ki_o}, 32'h0);
  endtask

  // a reset in mid-run brings every written field back to its reset value
  task automatic t_reset_again;
    wr(8'h31, 8'h01);
    wr(8'h35, 8'h40);
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    bus(1'b0, 8'h31, 8'h00, 1'b1, q);
    chk(q, 32'h0);
    bus(1'b0, 8'h32, 8'h00, 1'b1, q);
    chk(q, 32'h0);
    bus(1'b0, 8'h33, 8'h00, 1'b1, q);
    chk(q, 32'h0);
    bus(1'b0, 8'h34, 8'h00, 1'b1, q);
    chk(q, 32'h0);
    bus(1'b0, 8'h35, 8'h00, 1'b1, q);
    chk(q, 32'hff);
  endtask

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    clk_i       = 1'b0;
    rst_i       = 1'b1;
    wb_cyc_i    = 1'b0;
    wb_stb_i    = 1'b0;
    wb_we_i     = 1'b0;
    wb_adr_i    = 10'h000;
    wb_sel_i    = 4'h0;
    wb_dat_i    = 32'h0;
    coil_freq_i = 9'h000;
    n_fail      = 0;
    compares    = 0;
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_regs();
    t_div();
    t_thr();
    t_disable();
    t_reset_again();
    summarize();
  end
endmodule
`default_nettype wire
